// file: logic/rss_sequencer.sv
// Purpose: Start-up, addressing and shut-down sequencer of a step-down regulator.
// Assumes: All inputs synchronous to clock; bus pins sampled at 20 MHz.
// Notes: Bus data pin is open drain; enable high pulls it low.
`timescale 1ns/1ps
module rss_sequencer #(
	parameter logic [7:0] PART_ID = 8'h5a, // Arbitrary value.
	parameter int         LW      = 13
) (
	// Clock and reset
	input  wire logic          clock,
	input  wire logic          srst,
	// Supply lockout and enable
	input  wire logic          supply_lockout_level,
	input  wire logic          enable_in,
	// Non-volatile memory read port, data valid one cycle after request
	output logic               nvm_rd_en,
	output logic         [2:0] nvm_addr,
	input  wire logic    [7:0] nvm_rdata,
	// Address strap comparators, thermometer coded
	input  wire logic    [2:0] strap_thermo,
	// Two-wire bus
	input  wire logic          scl_in,
	input  wire logic          sda_in,
	output logic               sda_out,
	output logic               sda_oe,
	// Regulation
	input  wire logic [LW-1:0] output_sense_input,
	output logic      [LW-1:0] ref_level_mv,
	output logic               high_side_pulse,
	output logic               low_side_pulse,
	output logic               drivers_on,
	output logic               min_on_time,
	output logic               protect_enable,
	output logic               output_ok_flag,
	output logic               io_level_high,
	output logic               init_done
);
	rss_pkg::rss_seq_t   seq_r;
	rss_pkg::rss_phase_t ph_r;
	rss_pkg::rss_bus_t   bs_r;

	logic [7:0] base_id_r, tgt_up_r, tgt_lo_r, ramp_stop_r, io_lvl_r, stop_arm_r;
	logic [2:0] ld_idx_r;
	logic       ld_vld_r;
	logic [1:0] offset_r;
	logic [1:0] ones;
	logic [6:0] dev_addr;
	logic [LW-1:0] target_mv;
	logic       stop_both, ramp_clear, ramp_up, ramp_down, at_zero;

	// Bus engine state.
	logic       scl_p, sda_p;
	logic       start_c, stop_c, rise_c, fall_c;
	logic [3:0] cnt_r;
	logic [7:0] sh_r, tx_r, ptr_r;
	logic       rw_r, first_r, nack_r;
	logic       wr_stb_r;
	logic [7:0] wr_addr_r, wr_data_r;
	logic [7:0] rd_data;

	// Start-up: lockout, memory load, strap sampling.
	always_ff @(posedge clock) begin
		if (srst || !supply_lockout_level) begin
			seq_r    <= rss_pkg::SQ_LOCK;
			ld_idx_r <= 3'h0;
			ld_vld_r <= 1'b0;
		end else begin
			ld_vld_r <= (seq_r == rss_pkg::SQ_LOAD);
			case (seq_r)
				rss_pkg::SQ_LOCK: begin
					seq_r <= rss_pkg::SQ_LOAD;
				end
				rss_pkg::SQ_LOAD: begin
					if (ld_idx_r == rss_pkg::NVM_LAST) begin
						seq_r <= rss_pkg::SQ_STRAP;
					end else begin
						ld_idx_r <= ld_idx_r + 3'h1;
					end
				end
				rss_pkg::SQ_STRAP: begin
					seq_r <= rss_pkg::SQ_READY;
				end
				default: begin
					seq_r <= seq_r;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			nvm_rd_en <= 1'b0;
			nvm_addr  <= 3'h0;
			init_done <= 1'b0;
		end else begin
			nvm_rd_en <= supply_lockout_level && (seq_r == rss_pkg::SQ_LOAD);
			nvm_addr  <= ld_idx_r;
			init_done <= supply_lockout_level && (seq_r == rss_pkg::SQ_READY);
		end
	end

	// Comparators give a thermometer code; the count of ones is the offset.
	assign ones = 2'(strap_thermo[0]) + 2'(strap_thermo[1]) + 2'(strap_thermo[2]);

	always_ff @(posedge clock) begin
		if (srst) begin
			offset_r <= 2'h0;
		end else if (seq_r == rss_pkg::SQ_STRAP) begin
			offset_r <= ones;
		end
	end

	assign dev_addr = base_id_r[6:0] + 7'(offset_r);

	// Working registers: memory load, then host writes.
	always_ff @(posedge clock) begin
		if (srst) begin
			base_id_r   <= rss_pkg::RST_BASE_ID;
			tgt_up_r    <= rss_pkg::RST_TGT_UPPER;
			tgt_lo_r    <= rss_pkg::RST_TGT_LOWER;
			ramp_stop_r <= rss_pkg::RST_RAMP_STOP;
			io_lvl_r    <= rss_pkg::RST_IO_LEVEL;
			stop_arm_r  <= rss_pkg::RST_STOP_ARM;
		end else if (ld_vld_r) begin
			case (nvm_addr)
				rss_pkg::NVM_BASE_ID:   base_id_r   <= nvm_rdata;
				rss_pkg::NVM_TGT_UPPER: tgt_up_r    <= nvm_rdata & 8'h01;
				rss_pkg::NVM_TGT_LOWER: tgt_lo_r    <= nvm_rdata;
				rss_pkg::NVM_RAMP_STOP: ramp_stop_r <= nvm_rdata & rss_pkg::STOP_BITS_CLR;
				rss_pkg::NVM_IO_LEVEL:  io_lvl_r    <= nvm_rdata;
				rss_pkg::NVM_STOP_ARM:  stop_arm_r  <= nvm_rdata & rss_pkg::STOP_BITS_CLR;
				default: begin
					base_id_r <= base_id_r;
				end
			endcase
		end else if (wr_stb_r) begin
			case (wr_addr_r)
				rss_pkg::REG_TGT_UPPER: tgt_up_r    <= wr_data_r & 8'h01;
				rss_pkg::REG_TGT_LOWER: tgt_lo_r    <= wr_data_r;
				rss_pkg::REG_RAMP_STOP: ramp_stop_r <= wr_data_r;
				rss_pkg::REG_IO_LEVEL:  io_lvl_r    <= wr_data_r;
				rss_pkg::REG_STOP_ARM:  stop_arm_r  <= wr_data_r;
				rss_pkg::REG_BASE_ID:   base_id_r   <= wr_data_r;
				default: begin
					base_id_r <= base_id_r;
				end
			endcase
		end
	end

	always_comb begin
		case (ptr_r)
			rss_pkg::REG_PART_ID:   rd_data = PART_ID;
			rss_pkg::REG_TGT_UPPER: rd_data = tgt_up_r;
			rss_pkg::REG_TGT_LOWER: rd_data = tgt_lo_r;
			rss_pkg::REG_RAMP_STOP: rd_data = ramp_stop_r;
			rss_pkg::REG_IO_LEVEL:  rd_data = io_lvl_r;
			rss_pkg::REG_STOP_ARM:  rd_data = stop_arm_r;
			rss_pkg::REG_BASE_ID:   rd_data = base_id_r;
			default:                rd_data = 8'h00;
		endcase
	end

	// Bus engine. One sample of history is enough since the pins are clean here.
	assign start_c = scl_in && scl_p && sda_p && !sda_in;
	assign stop_c  = scl_in && scl_p && !sda_p && sda_in;
	assign rise_c  = scl_in && !scl_p;
	assign fall_c  = !scl_in && scl_p;

	always_ff @(posedge clock) begin
		if (srst) begin
			scl_p <= 1'b1;
			sda_p <= 1'b1;
		end else begin
			scl_p <= scl_in;
			sda_p <= sda_in;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			bs_r      <= rss_pkg::BS_IDLE;
			cnt_r     <= 4'h0;
			sh_r      <= 8'h00;
			tx_r      <= 8'h00;
			ptr_r     <= 8'h00;
			rw_r      <= 1'b0;
			first_r   <= 1'b0;
			nack_r    <= 1'b0;
			sda_oe    <= 1'b0;
			sda_out   <= 1'b0;
			wr_stb_r  <= 1'b0;
			wr_addr_r <= 8'h00;
			wr_data_r <= 8'h00;
		end else begin
			sda_out  <= 1'b0;
			wr_stb_r <= 1'b0;
			if (!init_done || stop_c) begin
				bs_r   <= rss_pkg::BS_IDLE;
				sda_oe <= 1'b0;
			end else if (start_c) begin
				bs_r    <= rss_pkg::BS_ADDR;
				cnt_r   <= 4'h0;
				first_r <= 1'b1;
				sda_oe  <= 1'b0;
			end else if (rise_c) begin
				if (bs_r == rss_pkg::BS_ADDR || bs_r == rss_pkg::BS_WR) begin
					sh_r  <= {sh_r[6:0], sda_in};
					cnt_r <= cnt_r + 4'h1;
				end else if (bs_r == rss_pkg::BS_RD) begin
					cnt_r <= cnt_r + 4'h1;
				end else if (bs_r == rss_pkg::BS_ACK_R) begin
					nack_r <= sda_in;
				end
			end else if (fall_c) begin
				case (bs_r)
					rss_pkg::BS_ADDR: begin
						if (cnt_r == 4'h8) begin
							if (sh_r[7:1] == dev_addr) begin
								bs_r   <= rss_pkg::BS_ACK_A;
								rw_r   <= sh_r[0];
								sda_oe <= 1'b1;
							end else begin
								bs_r <= rss_pkg::BS_IDLE;
							end
						end
					end
					rss_pkg::BS_ACK_A, rss_pkg::BS_ACK_R: begin
						cnt_r <= 4'h0;
						if (bs_r == rss_pkg::BS_ACK_R && nack_r) begin
							bs_r   <= rss_pkg::BS_IDLE;
							sda_oe <= 1'b0;
						end else if (rw_r) begin
							bs_r   <= rss_pkg::BS_RD;
							tx_r   <= rd_data;
							sda_oe <= !rd_data[7];
							ptr_r  <= ptr_r + 8'h01;
						end else begin
							bs_r   <= rss_pkg::BS_WR;
							sda_oe <= 1'b0;
						end
					end
					rss_pkg::BS_WR: begin
						if (cnt_r == 4'h8) begin
							bs_r    <= rss_pkg::BS_ACK_W;
							sda_oe  <= 1'b1;
							first_r <= 1'b0;
							if (first_r) begin
								ptr_r <= sh_r;
							end else begin
								wr_stb_r  <= 1'b1;
								wr_addr_r <= ptr_r;
								wr_data_r <= sh_r;
								ptr_r     <= ptr_r + 8'h01;
							end
						end
					end
					rss_pkg::BS_ACK_W: begin
						bs_r   <= rss_pkg::BS_WR;
						cnt_r  <= 4'h0;
						sda_oe <= 1'b0;
					end
					rss_pkg::BS_RD: begin
						if (cnt_r == 4'h8) begin
							bs_r   <= rss_pkg::BS_ACK_R;
							sda_oe <= 1'b0;
						end else begin
							tx_r   <= {tx_r[6:0], 1'b0};
							sda_oe <= !tx_r[6];
						end
					end
					default: begin
						sda_oe <= 1'b0;
					end
				endcase
			end
		end
	end

	// Regulation sequence.
	assign target_mv = LW'({tgt_up_r[0], tgt_lo_r}) * LW'(rss_pkg::STEP_MV)
		+ LW'(rss_pkg::OFFSET_MV);
	assign stop_both = ramp_stop_r[rss_pkg::BIT_STOP_REQ]
		&& stop_arm_r[rss_pkg::BIT_STOP_ARM];
	assign ramp_clear = !enable_in || !init_done || (ph_r == rss_pkg::PH_OFF)
		|| (ph_r == rss_pkg::PH_PARK);
	assign ramp_up    = (ph_r == rss_pkg::PH_WAIT) || (ph_r == rss_pkg::PH_RUN);
	assign ramp_down  = (ph_r == rss_pkg::PH_STOP);

	rss_ramp #(
		.W(LW)
	) u_ramp (
		.clock   (clock),
		.srst    (srst),
		.clear   (ramp_clear),
		.go_up   (ramp_up),
		.go_down (ramp_down),
		.fast    (ramp_stop_r[rss_pkg::BIT_RAMP_FAST]),
		.target  (target_mv),
		.level   (ref_level_mv),
		.at_zero (at_zero)
	);

	always_ff @(posedge clock) begin
		if (srst || !enable_in || !init_done) begin
			ph_r            <= rss_pkg::PH_OFF;
			drivers_on      <= 1'b0;
			high_side_pulse <= 1'b0;
			low_side_pulse  <= 1'b0;
			output_ok_flag  <= 1'b0;
		end else begin
			high_side_pulse <= 1'b0;
			low_side_pulse  <= high_side_pulse;
			case (ph_r)
				rss_pkg::PH_OFF: begin
					ph_r <= stop_both ? rss_pkg::PH_PARK : rss_pkg::PH_WAIT;
				end
				rss_pkg::PH_WAIT: begin
					if (ref_level_mv > output_sense_input) begin
						ph_r            <= rss_pkg::PH_RUN;
						drivers_on      <= 1'b1;
						high_side_pulse <= 1'b1;
					end
				end
				rss_pkg::PH_RUN: begin
					output_ok_flag <= 1'b1;
					if (stop_both) begin
						ph_r <= rss_pkg::PH_STOP;
					end
				end
				rss_pkg::PH_STOP: begin
					if (!stop_both) begin
						ph_r <= rss_pkg::PH_RUN;
					end else if (at_zero) begin
						ph_r           <= rss_pkg::PH_PARK;
						drivers_on     <= 1'b0;
						output_ok_flag <= 1'b0;
					end
				end
				rss_pkg::PH_PARK: begin
					if (!stop_both) begin
						ph_r <= rss_pkg::PH_WAIT;
					end
				end
				default: begin
					ph_r <= rss_pkg::PH_OFF;
				end
			endcase
		end
	end

	// Protection must never lapse while the reference moves or the stage switches.
	always_ff @(posedge clock) begin
		if (srst) begin
			protect_enable <= 1'b0;
			min_on_time    <= 1'b0;
			io_level_high  <= 1'b0;
		end else begin
			protect_enable <= (ph_r != rss_pkg::PH_OFF) && (ph_r != rss_pkg::PH_PARK);
			min_on_time    <= drivers_on && (output_sense_input < target_mv);
			io_level_high  <= io_lvl_r[rss_pkg::BIT_IO_HIGH];
		end
	end
endmodule : rss_sequencer

// file: logic/rss_pkg.sv
// Purpose: Shared constants of the regulator start-up sequencer.
// Assumes: 20 MHz clock; register bytes reached over the two-wire bus.
// Notes: Offsets, field positions, reset values and timing counts.
package rss_pkg;
	localparam logic [7:0] REG_PART_ID   = 8'h04;
	localparam logic [7:0] REG_TGT_UPPER = 8'h12;
	localparam logic [7:0] REG_TGT_LOWER = 8'h13;
	localparam logic [7:0] REG_RAMP_STOP = 8'h14;
	localparam logic [7:0] REG_IO_LEVEL  = 8'h1a;
	localparam logic [7:0] REG_STOP_ARM  = 8'h1c;
	localparam logic [7:0] REG_BASE_ID   = 8'h20;

	localparam int BIT_OK_MODE   = 0;
	localparam int BIT_RAMP_FAST = 1;
	localparam int BIT_STOP_REQ  = 2;
	localparam int BIT_IO_HIGH   = 1;
	localparam int BIT_STOP_ARM  = 3;

	localparam logic [7:0] RST_BASE_ID   = 8'h08;
	localparam logic [7:0] RST_RAMP_STOP = 8'h01;
	localparam logic [7:0] RST_IO_LEVEL  = 8'h00;
	localparam logic [7:0] RST_STOP_ARM  = 8'h00;
	localparam logic [7:0] RST_TGT_UPPER = 8'h01;
	localparam logic [7:0] RST_TGT_LOWER = 8'h04;
	localparam logic [7:0] STOP_BITS_CLR = 8'hf3;

	// Non-volatile word index of each working register.
	localparam logic [2:0] NVM_BASE_ID   = 3'h0;
	localparam logic [2:0] NVM_TGT_UPPER = 3'h1;
	localparam logic [2:0] NVM_TGT_LOWER = 3'h2;
	localparam logic [2:0] NVM_RAMP_STOP = 3'h3;
	localparam logic [2:0] NVM_IO_LEVEL  = 3'h4;
	localparam logic [2:0] NVM_STOP_ARM  = 3'h5;
	localparam logic [2:0] NVM_LAST      = 3'h5;

	// Level arithmetic in millivolts; ramp timing in nanoseconds and clock cycles.
	localparam int STEP_MV   = 10;
	localparam int OFFSET_MV = 800;
	localparam int CLK_NS    = 50;
	localparam int SLOW_NS_PER_MV = 1000;
	localparam int FAST_NS_PER_MV = 500;
	localparam logic [4:0] SLOW_CYC = 5'(SLOW_NS_PER_MV / CLK_NS);
	localparam logic [4:0] FAST_CYC = 5'(FAST_NS_PER_MV / CLK_NS);

	typedef enum logic [1:0] {SQ_LOCK, SQ_LOAD, SQ_STRAP, SQ_READY} rss_seq_t;
	typedef enum logic [2:0] {PH_OFF, PH_WAIT, PH_RUN, PH_STOP, PH_PARK} rss_phase_t;
	typedef enum logic [2:0] {
		BS_IDLE, BS_ADDR, BS_ACK_A, BS_WR, BS_ACK_W, BS_RD, BS_ACK_R
	} rss_bus_t;
endpackage : rss_pkg

// file: logic/rss_ramp.sv
// Purpose: Soft-start reference level stepping one millivolt at a time.
// Assumes: Target and level in millivolts; clear wins over all else.
// Notes: Falling target is followed down at the same rate.
`timescale 1ns/1ps
module rss_ramp #(
	parameter int W = 13
) (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         srst,
	// Control
	input  wire logic         clear,
	input  wire logic         go_up,
	input  wire logic         go_down,
	input  wire logic         fast,
	input  wire logic [W-1:0] target,
	// Level
	output logic      [W-1:0] level,
	output logic              at_zero
);
	logic [4:0] div_r;
	logic       step;

	assign step = (div_r == 5'h00);

	always_ff @(posedge clock) begin
		if (srst || clear || !(go_up || go_down)) begin
			div_r <= 5'h00;
		end else if (step) begin
			div_r <= (fast ? rss_pkg::FAST_CYC : rss_pkg::SLOW_CYC) - 5'h01;
		end else begin
			div_r <= div_r - 5'h01;
		end
	end

	always_ff @(posedge clock) begin
		if (srst || clear) begin
			level <= '0;
		end else if (step && go_down) begin
			if (level != '0) begin
				level <= level - W'(1);
			end
		end else if (step && go_up) begin
			if (level < target) begin
				level <= level + W'(1);
			end else if (level > target) begin
				level <= level - W'(1);
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst || clear) begin
			at_zero <= 1'b1;
		end else begin
			at_zero <= (level == '0) || (step && go_down && level == W'(1));
		end
	end
endmodule : rss_ramp

// file: sim/rss_host.sv
// Purpose: Two-wire bus master standing in for the host controller.
// Assumes: The device samples the bus pins with the system clock.
// Notes: Each bus clock half phase lasts four system clocks.
`timescale 1ns/1ps
module rss_host (
	// Clock
	input  wire logic clock,
	// Bus wires
	input  wire logic sda_oe,
	output logic      scl,
	output wire logic sda
);
	logic drv_low;

	// Pulled-up line: once both sides let go it reads 1, never a stale level.
	assign sda = !(drv_low || sda_oe);

	initial begin
		scl = 1'b1;
		drv_low = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask : tick

	task automatic start_c;
		drv_low = 1'b0;
		tick(2);
		scl = 1'b1;
		tick(4);
		drv_low = 1'b1;
		tick(4);
		scl = 1'b0;
		tick(2);
	endtask : start_c

	task automatic stop_c;
		drv_low = 1'b1;
		tick(2);
		scl = 1'b1;
		tick(4);
		drv_low = 1'b0;
		tick(4);
	endtask : stop_c

	// Eight data bits, then the ninth bit; a 1 releases the line so the device may drive.
	task automatic xbyte(input logic [7:0] d, input logic nack, output logic [7:0] q,
			output logic ack);
		logic [8:0] w;
		w = {d, nack};
		for (int i = 8; i >= 0; i--) begin
			drv_low = !w[i];
			tick(2);
			scl = 1'b1;
			tick(2);
			if (i > 0) begin
				q[i-1] = sda;
			end else begin
				ack = !sda;
			end
			tick(2);
			scl = 1'b0;
			tick(2);
		end
	endtask : xbyte
endmodule : rss_host

// file: sim/rss_sequencer_chk.sv
// Purpose: Port assertions of the regulator start-up sequencer.
// Assumes: One clock domain; the synchronous reset disables every check.
// Notes: Bound to the top module below.
`timescale 1ns/1ps
module rss_sequencer_chk #(
	parameter int LW = 13
) (
	// Clock and reset
	input wire logic          clock,
	input wire logic          srst,
	// Inputs
	input wire logic          supply_lockout_level,
	input wire logic          enable_in,
	input wire logic [LW-1:0] output_sense_input,
	// Outputs
	input wire logic          init_done,
	input wire logic          sda_oe,
	input wire logic [LW-1:0] ref_level_mv,
	input wire logic          high_side_pulse,
	input wire logic          low_side_pulse,
	input wire logic          drivers_on,
	input wire logic          protect_enable,
	input wire logic          output_ok_flag
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);

	wire ref_above = ref_level_mv > output_sense_input;

	sequence s_first_pulse;
		high_side_pulse ##1 low_side_pulse;
	endsequence
	// Between steps the level holds, unless a hard stop drops it to zero.
	sequence s_quiet;
		($stable(ref_level_mv) || ref_level_mv == '0) [*8];
	endsequence

	property p_silent;
		!init_done |-> !sda_oe;
	endproperty
	a_silent: assert property (p_silent) else $error("bus answered before init");
	property p_lock;
		!supply_lockout_level [*2] |=> !init_done;
	endproperty
	a_lock: assert property (p_lock) else $error("init done under lockout");
	property p_step;
		$changed(ref_level_mv) && ref_level_mv != '0 |->
			ref_level_mv == $past(ref_level_mv) + 1'b1 || ref_level_mv + 1'b1 == $past(ref_level_mv);
	endproperty
	a_step: assert property (p_step) else $error("level moved by more than one");
	property p_gap;
		$changed(ref_level_mv) && ref_level_mv != '0 |=> s_quiet;
	endproperty
	a_gap: assert property (p_gap) else $error("level steps too close");
	property p_drop;
		!enable_in |=> !drivers_on && ref_level_mv == '0;
	endproperty
	a_drop: assert property (p_drop) else $error("hard stop not at once");
	property p_pair;
		$rose(drivers_on) |-> s_first_pulse;
	endproperty
	a_pair: assert property (p_pair) else $error("first pulse pair missing");
	property p_above;
		high_side_pulse |-> $past(ref_above);
	endproperty
	a_above: assert property (p_above) else $error("pulse before level passed output");
	property p_ok;
		$rose(output_ok_flag) |-> $past(high_side_pulse);
	endproperty
	a_ok: assert property (p_ok) else $error("output ok before first pulse");
	property p_park;
		$fell(drivers_on) |-> ref_level_mv == '0;
	endproperty
	a_park: assert property (p_park) else $error("drivers off above zero");
	property p_protect;
		drivers_on |-> protect_enable;
	endproperty
	a_protect: assert property (p_protect) else $error("switching unprotected");
endmodule : rss_sequencer_chk

bind rss_sequencer rss_sequencer_chk #(.LW(LW)) u_chk (
	.clock, .srst, .supply_lockout_level, .enable_in, .output_sense_input, .init_done,
	.sda_oe, .ref_level_mv, .high_side_pulse, .low_side_pulse, .drivers_on,
	.protect_enable, .output_ok_flag
);

// file: sim/rss_sequencer_bench.sv
// Purpose: Self-checking bench of the regulator start-up sequencer.
// Assumes: Inputs change at the falling clock edge; memory answers one cycle late.
// Notes: Ramps are checked over short spans so the run stays brief.
`timescale 1ns/1ps
module rss_sequencer_bench;
	localparam int LW = 13;
	localparam logic [7:0] PART_ID = 8'h3c; // Arbitrary value.
	localparam int TGT_MV = 'h148 * 10 + 10 * 400 / 5;

	logic          clock = 1'b0;
	logic          srst = 1'b1;
	logic          supply_lockout_level = 1'b0;
	logic          enable_in = 1'b0;
	logic [2:0]    strap_thermo = 3'h0;
	logic [7:0]    nvm_rdata = 8'h00;
	logic [LW-1:0] output_sense_input = '0;
	logic          nvm_rd_en, sda_oe, high_side_pulse, low_side_pulse, drivers_on;
	logic          min_on_time, protect_enable, output_ok_flag, io_level_high, init_done;
	logic [2:0]    nvm_addr;
	logic [LW-1:0] ref_level_mv;
	wire           scl_in;
	wire           sda_in;
	logic [6:0]    dev = 7'h08;
	int            error_cnt = 0;
	int            cmp_count = 0;
	int            cyc = 0;
	int            nvm_cnt = 0;
	// Stop bits are set in memory on purpose: the load must clear them.
	// The lower target word differs from its reset value, so a missed load shows up.
	logic [7:0]    nvm_mem [6] = '{8'h08, 8'h01, 8'h06, 8'h05, 8'h00, 8'h08};

	always #25 clock = ~clock;

	// Outside a request the port shows inverted words, so a stale sample cannot pass.
	always @(negedge clock) begin
		nvm_rdata <= nvm_rd_en ? nvm_mem[nvm_addr] : ~nvm_mem[nvm_addr];
		if (nvm_rd_en) begin
			nvm_cnt++;
		end
	end

	rss_sequencer #(.PART_ID(PART_ID), .LW(LW)) DUT (
		.clock, .srst, .supply_lockout_level, .enable_in, .nvm_rd_en, .nvm_addr, .nvm_rdata,
		.strap_thermo, .scl_in, .sda_in, .sda_out(), .sda_oe, .output_sense_input,
		.ref_level_mv, .high_side_pulse, .low_side_pulse, .drivers_on, .min_on_time,
		.protect_enable, .output_ok_flag, .io_level_high, .init_done
	);
	rss_host host (.clock, .sda_oe, .scl(scl_in), .sda(sda_in));

	task automatic give_verdict;
		$display("errors %0d comparisons %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : give_verdict

	always @(posedge clock) begin
		cyc++;
		if (cyc == 30000) begin
			error_cnt++;
			$display("[ERR] %0t run too long", $time);
			give_verdict;
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic cyc_n(input int n);
		repeat (n) @(negedge clock);
	endtask : cyc_n

	task automatic do_reset;
		srst = 1'b1;
		enable_in = 1'b0;
		supply_lockout_level = 1'b0;
		cyc_n(16);
		srst = 1'b0;
	endtask : do_reset

	task automatic power_up;
		supply_lockout_level = 1'b1;
		for (int n = 0; n < 100 && init_done !== 1'b1; n++) @(negedge clock);
	endtask : power_up

	task automatic probe(input logic [6:0] a, output logic ack);
		logic [7:0] q;
		host.start_c;
		host.xbyte({a, 1'b0}, 1'b1, q, ack);
		host.stop_c;
	endtask : probe

	task automatic wr(input logic [7:0] r, input logic [7:0] d);
		logic [7:0] q;
		logic a0, a1, a2;
		host.start_c;
		host.xbyte({dev, 1'b0}, 1'b1, q, a0);
		host.xbyte(r, 1'b1, q, a1);
		host.xbyte(d, 1'b1, q, a2);
		host.stop_c;
		chk({a0, a1, a2}, 16'h7, "write acks");
	endtask : wr

	task automatic rdc(input logic [7:0] r, input logic [7:0] e);
		logic [7:0] q, d;
		logic a0, a1, a2, a3;
		host.start_c;
		host.xbyte({dev, 1'b0}, 1'b1, q, a0);
		host.xbyte(r, 1'b1, q, a1);
		host.start_c;
		host.xbyte({dev, 1'b1}, 1'b1, q, a2);
		host.xbyte(8'hff, 1'b1, d, a3);
		host.stop_c;
		chk({a0, a1, a2}, 16'h7, "read acks");
		chk(d, e, "register read");
	endtask : rdc

	task automatic t_silent;
		logic ack;
		do_reset;
		nvm_cnt = 0;
		probe(dev, ack);
		chk(ack, 1'b0, "ack under lockout");
		chk(init_done, 1'b0, "init under lockout");
		power_up;
		chk(16'(nvm_cnt), 16'h6, "memory words loaded");
		probe(dev, ack);
		chk(ack, 1'b1, "ack after init");
	endtask : t_silent

	task automatic t_regs;
		rdc(rss_pkg::REG_PART_ID, PART_ID);
		wr(rss_pkg::REG_PART_ID, ~PART_ID);
		rdc(rss_pkg::REG_PART_ID, PART_ID);
		rdc(rss_pkg::REG_BASE_ID, 8'h08);
		rdc(rss_pkg::REG_TGT_LOWER, 8'h06);
		rdc(rss_pkg::REG_RAMP_STOP, 8'h01);
		rdc(rss_pkg::REG_STOP_ARM, 8'h00);
		rdc(8'h30, 8'h00);
		wr(rss_pkg::REG_IO_LEVEL, 8'h02);
		chk(io_level_high, 1'b1, "high bus range");
		wr(rss_pkg::REG_IO_LEVEL, 8'h00);
		chk(io_level_high, 1'b0, "low bus range");
	endtask : t_regs

	task automatic t_strap;
		logic ack;
		for (int k = 0; k < 4; k++) begin
			do_reset;
			strap_thermo = 3'((1 << k) - 1);
			power_up;
			// A strap that moves after start-up must not move the address.
			strap_thermo = ~strap_thermo;
			dev = 7'(8'h08 + k);
			probe(dev, ack);
			chk(ack, 1'b1, "strap address");
			probe(7'(8'h08 + (k + 1) % 4), ack);
			chk(ack, 1'b0, "other address");
		end
	endtask : t_strap

	task automatic t_ramp;
		logic [LW-1:0] r0;
		wr(rss_pkg::REG_TGT_UPPER, 8'h01);
		wr(rss_pkg::REG_TGT_LOWER, 8'h48);
		output_sense_input = 13'd20;
		enable_in = 1'b1;
		for (int n = 0; n < 1000 && ref_level_mv !== 13'd20; n++) @(negedge clock);
		chk(ref_level_mv, 16'd20, "ramp reached sense");
		chk(drivers_on, 1'b0, "drivers held off");
		chk(output_ok_flag, 1'b0, "output ok held off");
		chk(protect_enable, 1'b1, "protection in ramp");
		for (int n = 0; n < 100 && high_side_pulse !== 1'b1; n++) @(negedge clock);
		chk(ref_level_mv > 13'd20, 1'b1, "first pulse");
		cyc_n(1);
		chk({low_side_pulse, output_ok_flag}, 16'h3, "low pulse and ok");
		r0 = ref_level_mv;
		cyc_n(200);
		chk(ref_level_mv - r0, 16'd10, "slow rate");
		chk(min_on_time, 1'b1, "minimum on-time");
		output_sense_input = 13'(TGT_MV - 1);
		cyc_n(3);
		chk(min_on_time, 1'b1, "below target");
		output_sense_input = 13'(TGT_MV);
		cyc_n(3);
		chk(min_on_time, 1'b0, "at target");
		wr(rss_pkg::REG_RAMP_STOP, 8'h03);
		r0 = ref_level_mv;
		cyc_n(200);
		chk(ref_level_mv - r0, 16'd20, "fast rate");
	endtask : t_ramp

	task automatic t_stop;
		logic [LW-1:0] r0;
		enable_in = 1'b0;
		cyc_n(1);
		chk({drivers_on, ref_level_mv}, 16'h0, "hard stop");
		wr(rss_pkg::REG_STOP_ARM, 8'h08);
		output_sense_input = '0;
		enable_in = 1'b1;
		for (int n = 0; n < 300 && ref_level_mv !== 13'd15; n++) @(negedge clock);
		wr(rss_pkg::REG_RAMP_STOP, 8'h07);
		chk(drivers_on && ref_level_mv != '0, 1'b1, "stop starts above zero");
		r0 = ref_level_mv;
		cyc_n(100);
		chk(r0 - ref_level_mv, 16'd10, "stop rate");
		for (int n = 0; n < 1000 && ref_level_mv !== '0; n++) @(negedge clock);
		cyc_n(2);
		chk(drivers_on, 1'b0, "drivers off at zero");
		wr(rss_pkg::REG_RAMP_STOP, 8'h03);
		for (int n = 0; n < 100 && drivers_on !== 1'b1; n++) @(negedge clock);
		chk(drivers_on, 1'b1, "restart");
	endtask : t_stop

	initial begin
		t_silent;
		t_regs;
		t_strap;
		t_ramp;
		t_stop;
		give_verdict;
	end
endmodule : rss_sequencer_bench
